// ===== hdl/cmu_defs.svh
`ifndef CMU_DEFS_SVH
`define CMU_DEFS_SVH
`define CMU_OP_NOP      4'h0
`define CMU_OP_BM2      4'h1
`define CMU_OP_BM3      4'h2
`define CMU_OP_ACS      4'h3
`define CMU_OP_TB       4'h4
`define CMU_OP_FFT      4'h5
`define CMU_OP_CMPY     4'h6
`define CMU_OP_CLOAD    4'h7
`define CMU_OP_CSTORE   4'h8
`define CMU_OP_CRC      4'h9
`define CMU_OP_CRCWR    4'hA
`define CMU_CYC_BM2     3'h1
`define CMU_CYC_BM3     3'h2
`define CMU_CYC_ACS     3'h2
`define CMU_CYC_TB      3'h3
`define CMU_CYC_FFT     3'h5
`define CMU_CYC_ONE     3'h1
`define CMU_CRC_W8      2'h0
`define CMU_CRC_W16     2'h1
`define CMU_CRC_W24     2'h2
`define CMU_CRC_W32     2'h3
`define CMU_CRC_RST     32'h00000000
`define CMU_RES_RST     32'h00000000
`define CMU_NUM_RES     9
`define CMU_NUM_TB      2
`endif

// ===== hdl/cmu_pkg.sv
package cmu_pkg;
  typedef enum logic [1:0] {
    CMU_IDLE = 2'h0,
    CMU_BUSY = 2'h1,
    CMU_DONE = 2'h3
  } cmu_state_e;
  typedef logic [31:0] cmu_word_t;
endpackage

// ===== hdl/cmu_crc_byte.sv
`timescale 1ns/10ps
`default_nettype none
`include "cmu_defs.svh"
module cmu_crc_byte (
  input  wire logic [31:0] crc_i,   // running crc
  input  wire logic [7:0]  data_i,  // data byte
  input  wire logic [31:0] poly_i,  // polynomial, lsb aligned, low width bits
  input  wire logic [1:0]  width_i, // crc width select
  output logic      [31:0] crc_o    // updated crc
);
  // msb-first byte-at-a-time crc, computed left-aligned in 32 bits
  logic [31:0] c;
  logic [31:0] p;
  logic [31:0] shl;
  always_comb begin
    shl = 32'h00000000;
    unique case (width_i)
      `CMU_CRC_W8:  shl = 32'h00000018;
      `CMU_CRC_W16: shl = 32'h00000010;
      `CMU_CRC_W24: shl = 32'h00000008;
      `CMU_CRC_W32: shl = 32'h00000000;
    endcase
    c = crc_i << shl;
    p = poly_i << shl;
    c = c ^ {data_i, 24'h000000};
    for (int i = 0; i < 8; i++) begin
      c = c[31] ? ((c << 1) ^ p) : (c << 1);
    end
    crc_o = c >> shl;
  end
endmodule
`default_nettype wire

// ===== hdl/cmu_core.sv
`timescale 1ns/10ps
`default_nettype none
`include "cmu_defs.svh"
module cmu_core #(
  parameter int RES_N = `CMU_NUM_RES,
  parameter int TB_N  = `CMU_NUM_TB
) (
  input  wire logic        core_clk_i,  // 200 MHz core clock
  input  wire logic        rst_n_i,     // async reset, active low
  input  wire logic        op_valid_i,  // instruction issue
  input  wire logic [3:0]  op_code_i,   // operation select
  input  wire logic [3:0]  op_dst_i,    // destination result register
  input  wire logic [31:0] op_a_i,      // operand a
  input  wire logic [31:0] op_b_i,      // operand b
  input  wire logic [31:0] mem_rdata_i, // memory read word
  input  wire logic [3:0]  rd_sel_i,    // result register read select
  input  wire logic [1:0]  cfg_crcw_i,  // crc width
  input  wire logic [31:0] cfg_poly_i,  // crc polynomial
  output logic             stall_o,     // host pipeline stall
  output logic             done_o,      // operation complete pulse
  output logic      [31:0] rd_data_o,   // selected result register
  output logic      [31:0] crc_o,       // crc result register
  output logic      [31:0] tb0_o,       // traceback register 0
  output logic      [31:0] tb1_o,       // traceback register 1
  output logic      [31:0] status_o,    // config and status word
  output logic             mem_we_o,    // memory write strobe
  output logic      [31:0] mem_wdata_o  // memory write word, re:im
);
  // -----------------------------------------------------------------
  // state and storage
  // -----------------------------------------------------------------
  cmu_pkg::cmu_state_e st_r, st_nxt;
  logic [2:0]  cnt_r, cnt_nxt;
  logic [3:0]  op_r, op_nxt;
  logic [3:0]  dst_r, dst_nxt;
  logic [31:0] a_r, a_nxt;
  logic [31:0] b_r, b_nxt;
  logic [31:0] res_r [RES_N];
  logic [31:0] res_nxt [RES_N];
  logic [31:0] tb_r [TB_N];
  logic [31:0] tb_nxt [TB_N];
  logic [31:0] crc_r, crc_nxt;
  logic [31:0] wd_r, wd_nxt;
  logic        we_r, we_nxt;
  logic        done_r, done_nxt;
  logic [31:0] crc_upd;
  logic [31:0] result;
  logic [2:0]  lat;

  function automatic logic [2:0] op_cycles(input logic [3:0] op);
    unique case (op)
      `CMU_OP_BM2: op_cycles = `CMU_CYC_BM2;
      `CMU_OP_BM3: op_cycles = `CMU_CYC_BM3;
      `CMU_OP_ACS: op_cycles = `CMU_CYC_ACS;
      `CMU_OP_TB:  op_cycles = `CMU_CYC_TB;
      `CMU_OP_FFT: op_cycles = `CMU_CYC_FFT;
      default:     op_cycles = `CMU_CYC_ONE;
    endcase
  endfunction

  function automatic logic [15:0] sat16(input logic signed [32:0] v);
    if (v > 33'sh0_0000_7FFF) sat16 = 16'h7FFF;
    else if (v < -33'sh0_0000_8000) sat16 = 16'h8000;
    else sat16 = v[15:0];
  endfunction

  function automatic logic [15:0] absd(input logic [15:0] x, input logic [15:0] y);
    absd = (x > y) ? (x - y) : (y - x);
  endfunction

  // -----------------------------------------------------------------
  // datapath, fixed point only
  // -----------------------------------------------------------------
  cmu_crc_byte i_cmu_crc_byte (
    .crc_i   (crc_r),
    .data_i  (op_a_i[7:0]),
    .poly_i  (cfg_poly_i),
    .width_i (cfg_crcw_i),
    .crc_o   (crc_upd)
  );

  logic signed [31:0] pr_rr, pr_ii, pr_ri, pr_ir;
  logic signed [16:0] add_s, sub_s;
  always_comb begin
    pr_rr = $signed(a_r[31:16]) * $signed(b_r[31:16]);
    pr_ii = $signed(a_r[15:0]) * $signed(b_r[15:0]);
    pr_ri = $signed(a_r[31:16]) * $signed(b_r[15:0]);
    pr_ir = $signed(a_r[15:0]) * $signed(b_r[31:16]);
    add_s = $signed({a_r[15], a_r[15:0]}) + $signed({b_r[15], b_r[15:0]});
    sub_s = $signed({a_r[15], a_r[15:0]}) - $signed({b_r[15], b_r[15:0]});
    result = `CMU_RES_RST;
    unique case (op_r)
      `CMU_OP_BM2:  result = {16'h0000, absd(a_r[31:16], b_r[31:16]) + absd(a_r[15:0], b_r[15:0])};
      `CMU_OP_BM3:  result = {16'h0000, absd(a_r[31:16], b_r[31:16]) + absd(a_r[15:0], b_r[15:0])
                                        + absd(a_r[7:0] ^ a_r[15:8], b_r[7:0] ^ b_r[15:8])};
      `CMU_OP_ACS:  result = {sat16(33'(add_s)), sat16(33'(sub_s))};
      `CMU_OP_TB:   result = {tb_r[0][30:0], a_r[0]};
      `CMU_OP_FFT:  result = {sat16(33'($signed(a_r[31:16])) + 33'($signed(b_r[31:16]))),
                              sat16(33'($signed(a_r[31:16])) - 33'($signed(b_r[31:16])))};
      `CMU_OP_CMPY: result = {sat16(33'((pr_rr - pr_ii) >>> 15)), sat16(33'((pr_ri + pr_ir) >>> 15))};
      `CMU_OP_CLOAD: result = a_r;
      default:      result = `CMU_RES_RST;
    endcase
  end

  // -----------------------------------------------------------------
  // sequencer
  // -----------------------------------------------------------------
  always_comb begin
    st_nxt   = st_r;
    cnt_nxt  = cnt_r;
    op_nxt   = op_r;
    dst_nxt  = dst_r;
    a_nxt    = a_r;
    b_nxt    = b_r;
    crc_nxt  = crc_r;
    wd_nxt   = wd_r;
    we_nxt   = 1'b0;
    done_nxt = 1'b0;
    for (int i = 0; i < RES_N; i++) res_nxt[i] = res_r[i];
    for (int i = 0; i < TB_N; i++) tb_nxt[i] = tb_r[i];
    lat = op_cycles(op_code_i);
    unique case (st_r)
      cmu_pkg::CMU_IDLE, cmu_pkg::CMU_DONE: begin
        st_nxt = cmu_pkg::CMU_IDLE;
        if (op_valid_i) begin
          unique case (op_code_i)
            `CMU_OP_CRC: begin
              crc_nxt  = crc_upd;
              done_nxt = 1'b1;
            end
            `CMU_OP_CRCWR: begin
              crc_nxt  = op_a_i;
              done_nxt = 1'b1;
            end
            `CMU_OP_CSTORE: begin
              wd_nxt   = res_r[op_dst_i < 4'(RES_N) ? op_dst_i : 4'h0];
              we_nxt   = 1'b1;
              done_nxt = 1'b1;
            end
            `CMU_OP_NOP: begin
            end
            default: begin
              op_nxt  = op_code_i;
              dst_nxt = op_dst_i;
              a_nxt   = (op_code_i == `CMU_OP_CLOAD) ? mem_rdata_i : op_a_i;
              b_nxt   = op_b_i;
              cnt_nxt = lat - 3'h1;
              st_nxt  = cmu_pkg::CMU_BUSY;
            end
          endcase
        end
      end
      cmu_pkg::CMU_BUSY: begin
        if (cnt_r == 3'h0) begin
          if (dst_r < 4'(RES_N)) res_nxt[dst_r] = result;
          if (op_r == `CMU_OP_TB) begin
            tb_nxt[1] = tb_r[0];
            tb_nxt[0] = result;
          end
          done_nxt = 1'b1;
          st_nxt   = cmu_pkg::CMU_DONE;
        end else begin
          cnt_nxt = cnt_r - 3'h1;
        end
      end
      default: st_nxt = cmu_pkg::CMU_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r   <= cmu_pkg::CMU_IDLE;
      cnt_r  <= 3'h0;
      op_r   <= `CMU_OP_NOP;
      dst_r  <= 4'h0;
      a_r    <= `CMU_RES_RST;
      b_r    <= `CMU_RES_RST;
      crc_r  <= `CMU_CRC_RST;
      wd_r   <= `CMU_RES_RST;
      we_r   <= 1'b0;
      done_r <= 1'b0;
      for (int i = 0; i < RES_N; i++) res_r[i] <= `CMU_RES_RST;
      for (int i = 0; i < TB_N; i++) tb_r[i] <= `CMU_RES_RST;
    end else begin
      st_r   <= st_nxt;
      cnt_r  <= cnt_nxt;
      op_r   <= op_nxt;
      dst_r  <= dst_nxt;
      a_r    <= a_nxt;
      b_r    <= b_nxt;
      crc_r  <= crc_nxt;
      wd_r   <= wd_nxt;
      we_r   <= we_nxt;
      done_r <= done_nxt;
      for (int i = 0; i < RES_N; i++) res_r[i] <= res_nxt[i];
      for (int i = 0; i < TB_N; i++) tb_r[i] <= tb_nxt[i];
    end
  end

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  assign stall_o     = (st_r == cmu_pkg::CMU_BUSY);
  assign done_o      = done_r;
  assign rd_data_o   = (rd_sel_i < 4'(RES_N)) ? res_r[rd_sel_i] : `CMU_RES_RST;
  assign crc_o       = crc_r;
  assign tb0_o       = tb_r[0];
  assign tb1_o       = tb_r[1];
  assign status_o    = {25'h0000000, cfg_crcw_i, op_r, stall_o};
  assign mem_we_o    = we_r;
  assign mem_wdata_o = wd_r;
endmodule
`default_nettype wire

// ===== tb/cmu_core_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module cmu_core_chk #(
  parameter int RES_N = 9,
  parameter int TB_N  = 2
) (
  input wire logic        core_clk_i, // clock
  input wire logic        rst_n_i,    // reset
  input wire logic        op_valid_i, // issue
  input wire logic [3:0]  op_code_i,  // op
  input wire logic [31:0] op_a_i,     // operand a
  input wire logic [1:0]  cfg_crcw_i, // crc width
  input wire logic        stall_o,    // stall
  input wire logic        done_o,     // done
  input wire logic [31:0] crc_o,      // crc reg
  input wire logic        mem_we_o    // store
);
  // ------------------------------------------
  // issue decode, store tracking, properties
  // ------------------------------------------
  logic take;
  logic st_q;
  assign take = op_valid_i && !stall_o;
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) st_q <= 1'b0;
    else st_q <= take && op_code_i == 4'h8;
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  one_cyc_a: assert property (take && op_code_i inside {4'h1, 4'h6, 4'h7} |=> stall_o ##1 (!stall_o && done_o))
    else $error("one-cycle op latency wrong");
  two_cyc_a: assert property (take && op_code_i inside {4'h2, 4'h3} |=> stall_o [*2] ##1 (!stall_o && done_o))
    else $error("two-cycle op latency wrong");
  trace_lat_a: assert property (take && op_code_i == 4'h4 |=> stall_o [*3] ##1 (!stall_o && done_o))
    else $error("traceback latency wrong");
  fft_lat_a: assert property (take && op_code_i == 4'h5 |=> stall_o [*5] ##1 (!stall_o && done_o))
    else $error("fft stage latency wrong");
  crc_byte_a: assert property (take && op_code_i == 4'h9 |=> done_o && !stall_o)
    else $error("crc byte not absorbed in one cycle");
  crc_seed_a: assert property (take && op_code_i == 4'hA && cfg_crcw_i == 2'h3 |=> crc_o == $past(op_a_i))
    else $error("crc seed not written");
  store_we_a: assert property (take && op_code_i == 4'h8 |=> mem_we_o && done_o)
    else $error("store strobe missing");
  we_cause_a: assert property (mem_we_o |-> st_q)
    else $error("store strobe without store");
  done_free_a: assert property (done_o |-> !stall_o)
    else $error("done while stalled");
  cover property (take && op_code_i == 4'h5);
  cover property (take && op_code_i == 4'h9 ##1 take && op_code_i == 4'h9);
  cover property (mem_we_o);
endmodule
bind cmu_core cmu_core_chk #(.RES_N(RES_N), .TB_N(TB_N)) i_cmu_core_chk (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .op_valid_i(op_valid_i), .op_code_i(op_code_i),
  .op_a_i(op_a_i), .cfg_crcw_i(cfg_crcw_i), .stall_o(stall_o), .done_o(done_o), .crc_o(crc_o),
  .mem_we_o(mem_we_o)
);
`default_nettype wire

// ===== tb/cmu_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
module cmu_mem_model #(
  parameter logic [31:0] INIT = 32'h7FFF8001
) (
  input  wire logic        core_clk_i, // clock
  input  wire logic        rst_n_i,    // reset
  input  wire logic        we_i,       // store strobe
  input  wire logic [31:0] wdata_i,    // store word
  output logic      [31:0] rdata_o     // load word
);
  // --------------------------------
  // one complex word of data memory
  // --------------------------------
  logic [31:0] word_r;
  logic [31:0] word_nxt;
  always_comb word_nxt = we_i ? wdata_i : word_r;
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) word_r <= INIT;
    else word_r <= word_nxt;
  end
  assign rdata_o = word_r;
endmodule
`default_nettype wire

// ===== tb/cmu_core_bench.sv
`timescale 1ns/10ps
`default_nettype none
`include "cmu_defs.svh"
module cmu_core_bench;
  logic        core_clk_i, rst_n_i, op_valid_i, stall_o, done_o, mem_we_o;
  logic [3:0]  op_code_i, op_dst_i, rd_sel_i;
  logic [1:0]  cfg_crcw_i;
  logic [31:0] op_a_i, op_b_i, mem_rdata_i, cfg_poly_i, rd_data_o, crc_o, tb0_o, tb1_o, status_o, mem_wdata_o;
  int          n_errors, compares;
  localparam logic [31:0] MEM_INIT = 32'h7FFF8001;
  cmu_core i_cmu_core (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .op_valid_i(op_valid_i),
    .op_code_i(op_code_i), .op_dst_i(op_dst_i), .op_a_i(op_a_i), .op_b_i(op_b_i), .mem_rdata_i(mem_rdata_i),
    .rd_sel_i(rd_sel_i), .cfg_crcw_i(cfg_crcw_i), .cfg_poly_i(cfg_poly_i), .stall_o(stall_o), .done_o(done_o),
    .rd_data_o(rd_data_o), .crc_o(crc_o), .tb0_o(tb0_o), .tb1_o(tb1_o), .status_o(status_o),
    .mem_we_o(mem_we_o), .mem_wdata_o(mem_wdata_o));
  cmu_mem_model #(.INIT(MEM_INIT)) i_cmu_mem_model (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .we_i(mem_we_o), .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i));
  // ----------------------------
  // drivers, checks, scenarios
  // ----------------------------
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task put(input logic v, input logic [3:0] c, input logic [3:0] d, input logic [31:0] a);
    @(negedge core_clk_i);
    op_valid_i = v;
    op_code_i = c;
    op_dst_i = d;
    op_a_i = a;
  endtask
  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d, input logic [31:0] p,
                                           input int w);
    logic fb;
    for (int i = 7; i >= 0; i--) begin
      fb = c[w-1] ^ d[i];
      c = (c << 1) & (32'hFFFFFFFF >> (32 - w));
      if (fb) c = c ^ p;
    end
    return c;
  endfunction
  task t_reset;
    chk("idle outputs", 32'h0, {29'h0, stall_o, done_o, mem_we_o});
    chk("regs at reset", 32'h0, crc_o | tb0_o | tb1_o | status_o);
  endtask
  task t_lat;
    logic [3:0] ops [7];
    int cyc [7];
    int n;
    ops = '{`CMU_OP_BM2, `CMU_OP_BM3, `CMU_OP_ACS, `CMU_OP_TB, `CMU_OP_FFT, `CMU_OP_CMPY, `CMU_OP_CLOAD};
    cyc = '{1, 2, 2, 3, 5, 1, 1};
    cfg_crcw_i = `CMU_CRC_W32;
    for (int k = 0; k < 7; k++) begin
      put(1'b1, ops[k], 4'h0, 32'h3);
      put(1'b1, `CMU_OP_CRCWR, 4'h0, 32'hA5);
      n = 0;
      while (done_o !== 1'b1 && n < 20) begin
        if (stall_o === 1'b1) n++;
        put(1'b0, `CMU_OP_NOP, 4'h0, 32'h0);
      end
      chk("stall cycles", 32'(cyc[k]), 32'(n));
      chk("write while stalled", 32'h0, crc_o);
      if (ops[k] == `CMU_OP_TB) chk("traceback shift", 32'h1, tb0_o);
      if (ops[k] == `CMU_OP_CMPY) chk("complex product", 32'hFFFF0000, rd_data_o);
    end
  endtask
  task t_cplx;
    put(1'b1, `CMU_OP_CLOAD, 4'h2, 32'h0);
    put(1'b0, `CMU_OP_NOP, 4'h0, 32'h0);
    rd_sel_i = 4'h2;
    put(1'b1, `CMU_OP_CSTORE, 4'h2, 32'h0);
    chk("loaded word", MEM_INIT, rd_data_o);
    put(1'b0, `CMU_OP_NOP, 4'h0, 32'h0);
    chk("store strobe", 32'h1, {31'h0, mem_we_o});
    chk("stored word", MEM_INIT, mem_wdata_o);
  endtask
  task t_crc;
    logic [31:0] polys [4];
    logic [31:0] exp;
    logic [31:0] m;
    polys = '{32'h07, 32'h1021, 32'h864CFB, 32'h04C11DB7};
    for (int k = 0; k < 4; k++) begin
      m = 32'hFFFFFFFF >> (24 - 8 * k);
      cfg_crcw_i = 2'(k);
      cfg_poly_i = polys[k];
      put(1'b1, `CMU_OP_CRCWR, 4'h0, m);
      exp = m;
      for (int b = 0; b < 10; b++) begin
        put(1'b1, `CMU_OP_CRC, 4'h0, 32'(8'h31 + b));
        if (b == 0) chk("crc seed", m, crc_o);
        exp = crc_step(exp, 8'(8'h31 + b), polys[k], 8 * k + 8);
      end
      put(1'b0, `CMU_OP_NOP, 4'h0, 32'h0);
      chk("crc after ten bytes", exp, crc_o);
      // op field keeps the last sequenced op; crc, seed and store bypass the sequencer
      chk("status word", {25'h0, 2'(k), `CMU_OP_CLOAD, 1'b0}, status_o);
    end
  endtask
  task finish_test;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end
  initial begin
    #20000;
    n_errors++;
    finish_test;
  end
  initial begin
    n_errors = 0;
    compares = 0;
    {op_valid_i, op_code_i, op_dst_i, op_a_i, rd_sel_i, cfg_crcw_i, cfg_poly_i} = '0;
    op_b_i = 32'h00010002;
    rst_n_i = 1'b0;
    repeat (4) @(negedge core_clk_i);
    rst_n_i = 1'b1;
    t_reset;
    t_lat;
    t_cplx;
    t_crc;
    finish_test;
  end
endmodule
`default_nettype wire
